// >>> dms_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side: mains zero cross and fan tacho pulse sources
module dms_partner (
  input  wire logic clock,       // system clock
  input  wire logic zc_en,       // mains present
  input  wire logic tacho_en,    // rotor turning
  input  wire logic fan_run_cmd, // fan commanded on
  output logic      zero_cross,  // zero cross pulses
  output logic      fan_tacho    // tacho pulses
);
  // a rising edge every other clock; lines fall idle low when absent
  always_ff @(posedge clock)
  begin
    zero_cross <= zc_en ? (zero_cross !== 1'b1) : 1'b0;
    fan_tacho  <= (tacho_en && fan_run_cmd) ? (fan_tacho !== 1'b1) : 1'b0;
  end
endmodule
`default_nettype wire

// >>> dms_persist.sv
`timescale 1ns/1ps
`default_nettype none
module dms_persist
  import dms_pkg::*;
#(
  parameter int unsigned LIMIT = 10
)(
  input  wire logic clock,  // system clock
  input  wire logic resetn, // async reset, low
  input  wire logic tick,   // time base pulse
  input  wire logic cond,   // fault present
  output logic      hit     // persistence reached
);

  logic [7:0] cnt;

  // count ticks with fault, restart when absent
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      cnt <= 8'h00;
    else if (tick && !cond)
      cnt <= 8'h00;
    else if (tick && cnt != 8'(LIMIT - 1))
      cnt <= cnt + 8'h01;
  end

  assign hit = tick && cond && cnt == 8'(LIMIT - 1);

  property p_restart;
    @(posedge clock) disable iff (!resetn) tick && !cond |=> cnt == 8'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("timer kept count");

endmodule
`default_nettype wire

// >>> dms_pkg.sv
package dms_pkg;

  // ==========================================================
  // time base
  localparam int unsigned CLK_KHZ  = 125000;
  localparam int unsigned TICK_MS  = 100;
  localparam int unsigned TICK_DEF = TICK_MS * CLK_KHZ;

  // fault times in seconds
  localparam int unsigned T_LINK_S   = 25;
  localparam int unsigned T_RELAY_S  = 5;
  localparam int unsigned T_SENSE_S  = 1;
  localparam int unsigned T_TACHO_S  = 5;
  localparam int unsigned T_DRIVE_S  = 3;
  localparam int unsigned T_PAUSE_S  = 10;
  localparam int unsigned T_SUPPLY_S = 5;
  localparam int unsigned T_HOPEN_S  = 3;
  localparam int unsigned T_LEAK_S   = 12;
  localparam int unsigned FAN_TRIALS = 2;

  // times in ticks; "longer than" adds one tick
  localparam int unsigned N_LINK   = T_LINK_S * 1000 / TICK_MS;
  localparam int unsigned N_RELAY  = T_RELAY_S * 1000 / TICK_MS;
  localparam int unsigned N_SENSE  = T_SENSE_S * 1000 / TICK_MS + 1;
  localparam int unsigned N_TACHO  = T_TACHO_S * 1000 / TICK_MS;
  localparam int unsigned N_DRIVE  = T_DRIVE_S * 1000 / TICK_MS;
  localparam int unsigned N_PAUSE  = T_PAUSE_S * 1000 / TICK_MS;
  localparam int unsigned N_SUPPLY = T_SUPPLY_S * 1000 / TICK_MS;
  localparam int unsigned N_HOPEN  = T_HOPEN_S * 1000 / TICK_MS;
  localparam int unsigned N_LEAK   = T_LEAK_S * 1000 / TICK_MS + 1;

  // ==========================================================
  // converter limits
  localparam logic [9:0] ADC_HIGH   = 10'h3d4;
  localparam logic [9:0] ADC_NEG    = 10'h028;
  localparam logic [7:0] LEAK_FULL  = 8'hff;
  localparam logic [7:0] SPEED_1V   = 8'h33;
  localparam logic [7:0] SPEED_5V   = 8'hff;
  localparam logic [3:0] ZC_MIN_50  = 4'h5;
  localparam logic [3:0] ZC_MIN_60  = 4'h6;

  // ==========================================================
  // alarm bits
  localparam int N_AL = 13;
  localparam int AL_LINK = 0, AL_R1 = 1, AL_S1 = 2, AL_R2 = 3, AL_S2 = 4;
  localparam int AL_TSENSE = 5, AL_TOPEN = 6, AL_TACHO = 7, AL_DRIVE = 8;
  localparam int AL_SUPPLY = 9, AL_MICRO = 10, AL_HOPEN = 11, AL_LEAK = 12;
  localparam logic [12:0] AL_CLEARABLE = 13'h1c7f;
  localparam int unsigned PERSIST_N [13] = '{N_LINK, N_RELAY, N_SENSE, N_RELAY,
    N_SENSE, N_SENSE, N_SENSE, 0, 0, N_SUPPLY, 0, N_HOPEN, N_LEAK};

  // ==========================================================
  // register map
  localparam int ADDR_W = 5;
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_MAINS  = 5'h04;
  localparam logic [4:0] REG_SUPMIN = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_CLEAR  = 5'h10;
  localparam int CTRL_PB = 0, CTRL_60HZ = 1, CTRL_IDLE = 2, STAT_ACT = 16;
  localparam logic [2:0] CTRL_RST   = 3'h0;
  localparam logic [7:0] MAINS_RST  = 8'he6;
  localparam logic [9:0] SUPMIN_RST = 10'h000;

  typedef enum logic {TR_WATCH, TR_PAUSE} dms_trial_t;

endpackage

// >>> dms_supervisor.sv
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - link failure lasting 25 s raises the link alarm, retries go on
// - relay command versus sensed state mismatch for 5 s sets relay alarm
// - relay alarm requests drying skip and cool down
// - sensing out of limits above 980, or above 40 on negative half wave
// - sensing alarms need the fault for longer than 1 s
// - relay sensing check only while that relay is commanded off
// - thermostat sensing alarm is reported only, cycle continues
// - upper threshold 3/4 minus 1/16 of bulk reading, lower is half
// - thermostat sensing above upper threshold means automatic thermostat open
// - both relays off and sensing between thresholds means manual thermostat open
// - power board mode checks thermostat only when idle; no corrective action
// - fan commanded on with no tacho pulse for 5 s fails a trial
// - fan alarms latch after 2 failed trials, 10 s pause before retry
// - drive trial fails on command below 1 V running, or above 1 V stopped
// - fan alarms block with door open, ignore start/pause, clear at power-off
// - missing zero cross or low supply for 5 s stops, clears itself
// - mains frequency and minimum supply are configurable for supply checks
// - self-check or memory fault stores micro fault warning, not displayed
// - relays off and a heater sensing outside window 3 s sets heater open
// - leakage when line sensing above or below mains derived thresholds
// - leakage checked with door closed, alarm after more than 12 s
// - leakage alarm removes satellite power and skips its phases
module dms_supervisor
  import dms_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_DEF
)(
  input  wire logic              clock,                 // system clock
  input  wire logic              resetn,                // async reset, low
  input  wire logic [ADDR_W-1:0] address,               // byte address
  input  wire logic              read,                  // read request
  input  wire logic              write,                 // write request
  input  wire logic [31:0]       writedata,             // write data
  output logic      [31:0]       readdata,              // read data
  output logic                   waitrequest,           // slave busy
  input  wire logic              link_ok,               // satellite answers
  input  wire logic              heater_one_cmd,        // relay 1 driven
  input  wire logic              heater_two_cmd,        // relay 2 driven
  input  wire logic              heater_one_on_sensed,  // relay 1 seen closed
  input  wire logic              heater_two_on_sensed,  // relay 2 seen closed
  input  wire logic [9:0]        heater_one_sense,      // relay 1 sensing
  input  wire logic [9:0]        heater_two_sense,      // relay 2 sensing
  input  wire logic [9:0]        thermostat_sense,      // thermostat sensing
  input  wire logic              negative_half_wave,    // supply half wave
  input  wire logic [9:0]        bulk_voltage_reading,  // bulk reading
  input  wire logic              fan_run_cmd,           // fan commanded on
  input  wire logic              fan_tacho,             // tacho feedback
  input  wire logic [7:0]        speed_set_level,       // speed command level
  input  wire logic              zero_cross,            // zero cross signal
  input  wire logic [7:0]        line_sense,            // line relay sensing
  input  wire logic              door_closed,           // door shut
  input  wire logic              self_check_fail,       // protection check
  input  wire logic              memory_fault,          // program memory bad
  input  wire logic              start_pause_clear,     // clear pulse
  output logic      [N_AL-1:0]   alarm,                 // alarm flags
  output logic                   skip_drying,           // skip drying phase
  output logic                   cool_request,          // start cooling
  output logic                   block_door_open,       // block, door open
  output logic                   stop_machine,          // stop the cycle
  output logic                   satellite_power,       // satellite power on
  output logic                   skip_satellite_phases  // skip its phases
);

  // ==========================================================
  // registers and bus slave
  logic [2:0]      ctrl;
  logic [7:0]      mains;
  logic [9:0]      supply_min;
  logic            reg_clear;
  logic            req;
  logic            take;
  logic            clr;
  logic [31:0]     next_rd;
  logic [23:0]     tick_cnt;
  logic            tick;
  logic [N_AL-1:0] cond;
  logic [N_AL-1:0] hit;
  logic [N_AL-1:0] set;
  logic [N_AL-1:0] next_alarm;

  assign req  = read || write;
  assign take = req && !waitrequest;
  assign clr  = start_pause_clear || reg_clear;

  // one wait state per access
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      waitrequest <= 1'b1;
    else
      waitrequest <= !(req && waitrequest);
  end

  // read decode
  always_comb
  begin
    next_rd = 32'h0000_0000;
    if (address == REG_CTRL)
      next_rd[2:0] = ctrl;
    else if (address == REG_MAINS)
      next_rd[7:0] = mains;
    else if (address == REG_SUPMIN)
      next_rd[9:0] = supply_min;
    else if (address == REG_STATUS)
    begin
      next_rd[N_AL-1:0] = alarm;
      next_rd[STAT_ACT+5:STAT_ACT] = {skip_satellite_phases, satellite_power,
        stop_machine, block_door_open, cool_request, skip_drying};
    end
  end

  // read data captured in the wait cycle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      readdata <= 32'h0000_0000;
    else if (read && waitrequest)
      readdata <= next_rd;
  end

  // configuration writes
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl       <= CTRL_RST;
      mains      <= MAINS_RST;
      supply_min <= SUPMIN_RST;
    end
    else if (take && write)
    begin
      if (address == REG_CTRL)
        ctrl <= writedata[2:0];
      else if (address == REG_MAINS)
        mains <= writedata[7:0];
      else if (address == REG_SUPMIN)
        supply_min <= writedata[9:0];
    end
  end

  // software clear pulse
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      reg_clear <= 1'b0;
    else
      reg_clear <= take && write && address == REG_CLEAR && writedata[0];
  end

  // ==========================================================
  // time base
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      tick_cnt <= 24'h000000;
    else if (tick)
      tick_cnt <= 24'h000000;
    else
      tick_cnt <= tick_cnt + 24'h000001;
  end

  assign tick = tick_cnt == 24'(TICK_CYCLES - 1);

  // ==========================================================
  // thresholds
  logic [9:0] quarter;
  logic [9:0] h_thr;
  logic [9:0] l_thr;
  logic [7:0] leak_hi;
  logic [7:0] leak_lo;
  logic       both_off;
  logic       thermo_en;

  assign quarter  = {2'b00, bulk_voltage_reading[9:2]};
  assign h_thr    = quarter + quarter + quarter - {4'h0, bulk_voltage_reading[9:4]};
  assign l_thr    = {1'b0, bulk_voltage_reading[9:1]};
  assign leak_hi  = LEAK_FULL - ({3'h0, mains[7:3]} + {4'h0, mains[7:4]});
  assign leak_lo  = LEAK_FULL - ({1'b0, mains[7:1]} - {3'h0, mains[7:3]});
  assign both_off = !heater_one_cmd && !heater_two_cmd;
  assign thermo_en = !ctrl[CTRL_PB] || ctrl[CTRL_IDLE];

  function automatic logic out_lim(input logic [9:0] v, input logic neg);
    out_lim = v > ADC_HIGH || (neg && v > ADC_NEG);
  endfunction

  function automatic logic out_win(input logic [9:0] v, input logic [9:0] h, input logic [9:0] l);
    out_win = v > h || v < l;
  endfunction

  // ==========================================================
  // zero cross and tacho activity per tick
  logic       zc_q;
  logic [3:0] zc_cnt;
  logic       zc_ok;
  logic       tacho_q;
  logic       tacho_seen;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      zc_q   <= 1'b0;
      zc_cnt <= 4'h0;
      zc_ok  <= 1'b1;
    end
    else
    begin
      zc_q <= zero_cross;
      if (tick)
      begin
        zc_cnt <= 4'h0;
        zc_ok  <= zc_cnt >= (ctrl[CTRL_60HZ] ? ZC_MIN_60 : ZC_MIN_50);
      end
      else if (zero_cross && !zc_q && zc_cnt != 4'hf)
        zc_cnt <= zc_cnt + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      tacho_q    <= 1'b0;
      tacho_seen <= 1'b0;
    end
    else
    begin
      tacho_q <= fan_tacho;
      if (tick)
        tacho_seen <= 1'b0;
      else if (fan_tacho && !tacho_q)
        tacho_seen <= 1'b1;
    end
  end

  // ==========================================================
  // fault conditions
  always_comb
  begin
    cond = '0;
    cond[AL_LINK]   = !link_ok;
    cond[AL_R1]     = heater_one_cmd != heater_one_on_sensed;
    cond[AL_R2]     = heater_two_cmd != heater_two_on_sensed;
    cond[AL_S1]     = !heater_one_cmd && out_lim(heater_one_sense, negative_half_wave);
    cond[AL_S2]     = !heater_two_cmd && out_lim(heater_two_sense, negative_half_wave);
    cond[AL_TSENSE] = out_lim(thermostat_sense, negative_half_wave);
    cond[AL_TOPEN]  = thermo_en && (thermostat_sense > h_thr
      || (both_off && thermostat_sense > l_thr && thermostat_sense < h_thr));
    cond[AL_TACHO]  = fan_run_cmd && !tacho_seen && !(fan_tacho && !tacho_q);
    cond[AL_DRIVE]  = fan_run_cmd ? speed_set_level < SPEED_1V
      : (speed_set_level > SPEED_1V || speed_set_level == SPEED_5V);
    cond[AL_SUPPLY] = !zc_ok || bulk_voltage_reading < supply_min;
    cond[AL_HOPEN]  = both_off && (out_win(heater_one_sense, h_thr, l_thr)
      || out_win(heater_two_sense, h_thr, l_thr));
    cond[AL_LEAK]   = door_closed && (line_sense > leak_hi || line_sense < leak_lo);
  end

  // persistence timers, one per timed alarm except the two fan alarms
  generate
    for (genvar i = 0; i < N_AL; i++)
    begin : g_tmr
      if (PERSIST_N[i] != 0)
      begin : g_on
        dms_persist #(.LIMIT(PERSIST_N[i])) u_tmr (
          .clock  (clock),
          .resetn (resetn),
          .tick   (tick),
          .cond   (cond[i]),
          .hit    (hit[i])
        );
      end
      else
      begin : g_off
        assign hit[i] = 1'b0;
      end
    end
  endgenerate

  // fan retry sequencers
  logic tacho_latched;
  logic drive_latched;

  dms_trial #(.COND_T(N_TACHO), .PAUSE_T(N_PAUSE), .TRIALS(FAN_TRIALS)) u_tacho (
    .clock   (clock),
    .resetn  (resetn),
    .tick    (tick),
    .cond    (cond[AL_TACHO]),
    .latched (tacho_latched)
  );

  dms_trial #(.COND_T(N_DRIVE), .PAUSE_T(N_PAUSE), .TRIALS(FAN_TRIALS)) u_drive (
    .clock   (clock),
    .resetn  (resetn),
    .tick    (tick),
    .cond    (cond[AL_DRIVE]),
    .latched (drive_latched)
  );

  // ==========================================================
  // alarm latching, set wins over clear
  always_comb
  begin
    set = hit;
    set[AL_TACHO] = tacho_latched;
    set[AL_DRIVE] = drive_latched;
    set[AL_MICRO] = self_check_fail || memory_fault;
    next_alarm = set | (alarm & ~(clr ? AL_CLEARABLE : 13'h0000));
    next_alarm[AL_SUPPLY] = hit[AL_SUPPLY] || (alarm[AL_SUPPLY] && cond[AL_SUPPLY]);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      alarm <= '0;
    else
      alarm <= next_alarm;
  end

  // consequent actions
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      skip_drying           <= 1'b0;
      cool_request          <= 1'b0;
      block_door_open       <= 1'b0;
      stop_machine          <= 1'b0;
      satellite_power       <= 1'b0;
      skip_satellite_phases <= 1'b0;
    end
    else
    begin
      skip_drying           <= alarm[AL_R1] || alarm[AL_R2];
      cool_request          <= alarm[AL_R1] || alarm[AL_R2];
      block_door_open       <= alarm[AL_TACHO] || alarm[AL_DRIVE];
      stop_machine          <= alarm[AL_SUPPLY];
      satellite_power       <= !alarm[AL_LEAK];
      skip_satellite_phases <= alarm[AL_LEAK];
    end
  end

  // ==========================================================
  // checks
  sequence s_cool_started;
    skip_drying && cool_request;
  endsequence

  property p_relay_act;
    @(posedge clock) disable iff (!resetn) alarm[AL_R1] || alarm[AL_R2] |=> s_cool_started;
  endproperty
  a_relay_act: assert property (p_relay_act) else $error("relay alarm without cooling");

  property p_sense_gate;
    @(posedge clock) disable iff (!resetn) $rose(alarm[AL_S1]) |-> $past(!heater_one_cmd);
  endproperty
  a_sense_gate: assert property (p_sense_gate) else $error("sense alarm with relay on");

  property p_no_stop;
    @(posedge clock) disable iff (!resetn) !alarm[AL_SUPPLY] |=> !stop_machine;
  endproperty
  a_no_stop: assert property (p_no_stop) else $error("stop without supply alarm");

  property p_topen_gate;
    @(posedge clock) disable iff (!resetn)
      $rose(alarm[AL_TOPEN]) |-> $past(!ctrl[CTRL_PB] || ctrl[CTRL_IDLE]);
  endproperty
  a_topen_gate: assert property (p_topen_gate) else $error("thermostat check out of window");

  property p_fan_hold;
    @(posedge clock) disable iff (!resetn) alarm[AL_TACHO] |=> alarm[AL_TACHO] ##1 block_door_open;
  endproperty
  a_fan_hold: assert property (p_fan_hold) else $error("fan alarm not held");

  property p_supply_clear;
    @(posedge clock) disable iff (!resetn) alarm[AL_SUPPLY] && !cond[AL_SUPPLY] |=> !alarm[AL_SUPPLY];
  endproperty
  a_supply_clear: assert property (p_supply_clear) else $error("supply alarm stuck");

  property p_leak_door;
    @(posedge clock) disable iff (!resetn) $rose(alarm[AL_LEAK]) |-> $past(door_closed);
  endproperty
  a_leak_door: assert property (p_leak_door) else $error("leak alarm with door open");

  property p_leak_power;
    @(posedge clock) disable iff (!resetn) alarm[AL_LEAK] |=> !satellite_power && skip_satellite_phases;
  endproperty
  a_leak_power: assert property (p_leak_power) else $error("satellite powered in leak");

  property p_set_wins;
    @(posedge clock) disable iff (!resetn) hit[AL_HOPEN] && clr |=> alarm[AL_HOPEN];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

endmodule
`default_nettype wire

// >>> dms_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dms_supervisor_tb;
  import dms_pkg::*;
  localparam int TK = 16;
  logic        clock = 0, resetn = 0, read = 0, write = 0, zc_en = 1, tacho_en = 1, lok, scf, mfl;
  logic [4:0]  address = '0;
  logic [31:0] writedata = '0, readdata, rd;
  logic        waitrequest, h1c, h2c, h1s, h2s, nhw, fan, door, spc, skd, cool, blk, stp, satp, sks, zc, tach;
  logic [9:0]  h1v, h2v, thv, bulk;
  logic [7:0]  spd, line;
  logic [12:0] alarm;
  int          fails = 0, check_count = 0;

  // ==========================================================
  // clock, instances
  always #4 clock = ~clock;
  dms_supervisor #(.TICK_CYCLES(TK)) dms_supervisor_inst (.clock(clock), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .link_ok(lok), .heater_one_cmd(h1c), .heater_two_cmd(h2c), .heater_one_on_sensed(h1s),
    .heater_two_on_sensed(h2s), .heater_one_sense(h1v), .heater_two_sense(h2v), .thermostat_sense(thv),
    .negative_half_wave(nhw), .bulk_voltage_reading(bulk), .fan_run_cmd(fan), .fan_tacho(tach),
    .speed_set_level(spd), .zero_cross(zc), .line_sense(line), .door_closed(door), .self_check_fail(scf),
    .memory_fault(mfl), .start_pause_clear(spc), .alarm(alarm), .skip_drying(skd), .cool_request(cool),
    .block_door_open(blk), .stop_machine(stp), .satellite_power(satp), .skip_satellite_phases(sks));
  dms_partner dms_partner_inst (.clock(clock), .zc_en(zc_en), .tacho_en(tacho_en), .fan_run_cmd(fan),
    .zero_cross(zc), .fan_tacho(tach));

  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic r, input logic [4:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    address <= a;
    writedata <= wd;
    read <= r;
    write <= !r;
    do
    begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    if (n >= 50) fails++;
    read <= 0;
    write <= 0;
    @(posedge clock);
  endtask
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clock);
  endtask
  task automatic persist(input int b, input int n, input string nm);
    ticks(n - 1);
    chk(nm, 0, alarm[b]);
    ticks(2);
    chk(nm, 1, alarm[b]);
  endtask
  task automatic do_reset;
    resetn <= 0;
    {h2c, h2s, nhw, fan, spc, scf, mfl} <= '0;
    {h1c, h1s, door, zc_en, tacho_en, lok} <= '1;
    h1v <= 10'h0f0; h2v <= 10'h0f0; thv <= 10'h0f0; bulk <= 10'h190; spd <= 8'h00; line <= 8'hbe;
    repeat (5) @(posedge clock);
    resetn <= 1;
    repeat (2) @(posedge clock);
  endtask
  task automatic clear_pulse;
    spc <= 1;
    @(posedge clock);
    spc <= 0;
    repeat (2) @(posedge clock);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    do_reset;
    chk("alarm", 0, alarm);
    chk("sat_power", 1, satp);
    bus(1, REG_MAINS, 0);
    chk("mains", 32'he6, rd);
    bus(0, 5'h14, 32'h5a);
    bus(1, 5'h14, 0);
    chk("unmapped", 0, rd);
  endtask
  task automatic t_relay;
    do_reset;
    h2c <= 1;
    persist(AL_R2, N_RELAY, "relay2");
    chk("skip_dry", 1, skd);
    chk("cool", 1, cool);
    h2c <= 0;
    ticks(1);
    clear_pulse;
    chk("relay2 clr", 0, alarm[AL_R2]);
  endtask
  task automatic t_sense;
    do_reset;
    nhw <= 1; h2v <= 10'd40; h1v <= 10'd1000;
    ticks(N_SENSE + 4);
    chk("sense 40", 0, alarm[AL_S2]);
    h2v <= 10'd41;
    persist(AL_S2, N_SENSE, "sense2");
    chk("sense1 on", 0, alarm[AL_S1]);
    chk("tsense", 1, alarm[AL_TSENSE]);
    chk("tsense no stop", 0, stp);
    h1c <= 0;
    h1s <= 0;
    persist(AL_S1, N_SENSE, "sense1 off");
  endtask
  task automatic t_topen;
    do_reset;
    bus(0, REG_CTRL, 1);
    h1c <= 0; h1s <= 0;
    ticks(N_SENSE + 1);
    chk("topen gated", 0, alarm[AL_TOPEN]);
    bus(0, REG_CTRL, 5);
    persist(AL_TOPEN, N_SENSE, "topen man");
    chk("no stop", 0, stp);
    do_reset;
    thv <= 10'd276;
    persist(AL_TOPEN, N_SENSE, "topen auto");
  endtask
  task automatic t_fan;
    do_reset;
    fan <= 1; tacho_en <= 0;
    ticks(N_TACHO + N_PAUSE + N_TACHO - 2);
    chk("tacho early", 0, alarm[AL_TACHO]);
    chk("drive", 1, alarm[AL_DRIVE]);
    ticks(3);
    chk("tacho", 1, alarm[AL_TACHO]);
    chk("block", 1, blk);
    clear_pulse;
    chk("tacho held", 1, alarm[AL_TACHO]);
  endtask
  task automatic t_supply;
    do_reset;
    zc_en <= 0;
    persist(AL_SUPPLY, N_SUPPLY, "supply");
    chk("stop", 1, stp);
    zc_en <= 1;
    ticks(3);
    chk("supply off", 0, alarm[AL_SUPPLY]);
  endtask
  task automatic t_leak;
    do_reset;
    line <= 8'd214;
    persist(AL_LEAK, N_LEAK, "leak");
    chk("sat_power", 0, satp);
    chk("skip_sat", 1, sks);
  endtask
  task automatic t_hopen;
    do_reset;
    h1c <= 0;
    h1s <= 0;
    h2v <= 10'd100;
    persist(AL_HOPEN, N_HOPEN, "hopen");
    // clear lands exactly on a tick edge, where the timer hits again
    repeat (13) @(posedge clock);
    clear_pulse;
    chk("hopen set wins", 1, alarm[AL_HOPEN]);
    clear_pulse;
    chk("hopen clear", 0, alarm[AL_HOPEN]);
  endtask
  task automatic t_link;
    do_reset;
    lok <= 0;
    persist(AL_LINK, N_LINK, "link");
    lok <= 1;
    scf <= 1;
    repeat (2) @(posedge clock);
    chk("micro check", 1, alarm[AL_MICRO]);
    scf <= 0;
    bus(1, REG_STATUS, 0);
    chk("status", 32'h0010_0401, rd);
    bus(0, REG_CLEAR, 1);
    @(posedge clock);
    chk("reg clear", 0, alarm);
    mfl <= 1;
    repeat (2) @(posedge clock);
    chk("micro memory", 1, alarm[AL_MICRO]);
    mfl <= 0;
  endtask

  // ==========================================================
  // verdict and sequence
  task automatic print_verdict;
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #600000;
    fails++;
    print_verdict;
  end
  initial
  begin
    t_reset;
    t_relay;
    t_sense;
    t_topen;
    t_fan;
    t_supply;
    t_leak;
    t_hopen;
    t_link;
    print_verdict;
  end
endmodule
`default_nettype wire

// >>> dms_trial.sv
`timescale 1ns/1ps
`default_nettype none
module dms_trial
  import dms_pkg::*;
#(
  parameter int unsigned COND_T  = 50,
  parameter int unsigned PAUSE_T = 100,
  parameter int unsigned TRIALS  = 2
)(
  input  wire logic clock,  // system clock
  input  wire logic resetn, // async reset, low
  input  wire logic tick,   // time base pulse
  input  wire logic cond,   // trial fault present
  output logic      latched // alarm after last trial
);

  dms_trial_t state;
  logic [7:0] cnt;
  logic [1:0] fails;

  // watch, fail, pause, retry
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state   <= TR_WATCH;
      cnt     <= 8'h00;
      fails   <= 2'h0;
      latched <= 1'b0;
    end
    else if (tick && !latched)
    begin
      case (state)
        TR_WATCH:
          if (!cond)
          begin
            cnt   <= 8'h00;
            fails <= 2'h0;
          end
          else if (cnt == 8'(COND_T - 1))
          begin
            cnt <= 8'h00;
            if (fails == 2'(TRIALS - 1))
              latched <= 1'b1;
            else
            begin
              fails <= fails + 2'h1;
              state <= TR_PAUSE;
            end
          end
          else
            cnt <= cnt + 8'h01;
        TR_PAUSE:
          if (cnt == 8'(PAUSE_T - 1))
          begin
            cnt   <= 8'h00;
            state <= TR_WATCH;
          end
          else
            cnt <= cnt + 8'h01;
        default: state <= TR_WATCH;
      endcase
    end
  end

  property p_trials;
    @(posedge clock) disable iff (!resetn) $rose(latched) |-> $past(fails) == 2'(TRIALS - 1);
  endproperty
  a_trials: assert property (p_trials) else $error("latched before last trial");

endmodule
`default_nettype wire
